// [verilog/carsel_map.svh]
// Purpose: offsets, fields and codes of the carrier select block
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   included by the design and the bench
// Function
// [RL1] Select code picks carrier; 0000 is ground
// [RL2] Codes 1000 to 1111 connect nothing
// [RL3] Codes 0001/0010 route input pins one/two
// [RL4] Invert bit inverts selected low carrier
// [RL5] Low sync waits for low carrier fall
// [RL6] Sync clear switches carriers at once
// [RL7] Low control bit 4 reads zero
// [RL8] Carrier control bits readable, writable, held
// [RL9] Low layout: disable, invert, sync, select
// [RL10] High control mirrors low layout
// [RL11] Main control layout; bits 2,1 read zero
// [RL12] Output follows high or low carrier
`ifndef CARSEL_MAP_SVH
`define CARSEL_MAP_SVH

// ==================================================
// Register map
`define CARSEL_ADDR_W     8
`define CARSEL_OFS_MAIN   8'h00
`define CARSEL_OFS_SRC    8'h04
`define CARSEL_OFS_LOW    8'h08
`define CARSEL_OFS_HIGH   8'h0C
`define CARSEL_RESP_OKAY  2'h0
`define CARSEL_RESP_ERR   2'h2

// ==================================================
// Reset values
`define CARSEL_CAR_RST    7'h00
`define CARSEL_MAIN_RST   5'h00
`define CARSEL_SRC_RST    5'h00

// ==================================================
// Carrier select codes
`define CARSEL_SEL_GND    4'h0
`define CARSEL_SEL_PIN1   4'h1
`define CARSEL_SEL_PIN2   4'h2
`define CARSEL_SEL_CAPTURE_COMPARE_UNIT_THREE   4'h6
`define CARSEL_SEL_CAPTURE_COMPARE_UNIT_FOUR   4'h7
`define CARSEL_SEL_RSVD   3
`define CARSEL_SRC_SW     4'h0

`endif

// [verilog/carsel_pkg.sv]
// Purpose: types of the carrier select block
// Assumes: carsel_map.svh holds every number
// Notes:   field order matches the register bit order
package carsel_pkg;

  // ==================================================
  // Register fields
  typedef struct packed {
    logic       output_disable;
    logic       invert;
    logic       edge_sync;
    logic [3:0] sel;
  } carrier_ctrl_t;

  typedef struct packed {
    logic modulator_enable;
    logic modulator_output_enable;
    logic output_slew_limit;
    logic output_invert;
    logic software_modulation_bit;
  } main_ctrl_t;

  typedef struct packed {
    logic       source_output_disable;
    logic [3:0] modulation_source_select;
  } src_ctrl_t;

  // ==================================================
  // Active carrier
  typedef enum logic {CAR_LOW, CAR_HIGH} car_state_t;

endpackage

// [verilog/modulator_carrier_select.sv]
// Purpose: carrier select, polarity and edge sync of a modulator
// Assumes: carrier and modulation sources share ref_clk_i
// Notes:   only the two carrier pins cross in from outside
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`include "carsel_map.svh"

module modulator_carrier_select
  import carsel_pkg::*;
#(
  parameter int MOD_SRC_W = 16
) (
  // Clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      sys_rst_i,
  // AXI4-Lite write address
  input  wire logic                      s_axil_awvalid,
  output logic                           s_axil_awready,
  input  wire logic [`CARSEL_ADDR_W-1:0] s_axil_awaddr,
  input  wire logic [2:0]                s_axil_awprot,
  // AXI4-Lite write data
  input  wire logic                      s_axil_wvalid,
  output logic                           s_axil_wready,
  input  wire logic [31:0]               s_axil_wdata,
  input  wire logic [3:0]                s_axil_wstrb,
  // AXI4-Lite write response
  output logic                           s_axil_bvalid,
  input  wire logic                      s_axil_bready,
  output logic [1:0]                     s_axil_bresp,
  // AXI4-Lite read
  input  wire logic                      s_axil_arvalid,
  output logic                           s_axil_arready,
  input  wire logic [`CARSEL_ADDR_W-1:0] s_axil_araddr,
  input  wire logic [2:0]                s_axil_arprot,
  output logic                           s_axil_rvalid,
  input  wire logic                      s_axil_rready,
  output logic [31:0]                    s_axil_rdata,
  output logic [1:0]                     s_axil_rresp,
  // Carrier sources
  input  wire logic                      carrier_input_pin_one_i,
  input  wire logic                      carrier_input_pin_two_i,
  input  wire logic                      ref_clock_signal_i,
  input  wire logic [3:0]                capture_compare_out_i,
  input  wire logic [3:0]                capture_compare_pwm_i,
  // Modulation sources
  input  wire logic [MOD_SRC_W-1:0]      mod_source_i,
  // Modulated output pin and control
  output logic                           mod_out_o,
  output logic                           mod_out_oe_o,
  output logic                           output_slew_limit_o,
  // Source pin gating
  output logic                           low_carrier_drive_en_o,
  output logic                           high_carrier_drive_en_o,
  output logic                           source_drive_en_o
);

  // ==================================================
  // Registers
  carrier_ctrl_t low_r;
  carrier_ctrl_t high_r;
  main_ctrl_t    main_r;
  src_ctrl_t     src_r;

  // ==================================================
  // Bus slave state
  logic                      aw_ok_r;
  logic                      w_ok_r;
  logic [`CARSEL_ADDR_W-1:0] awaddr_r;
  logic [31:0]               wdata_r;
  logic [3:0]                wstrb_r;
  logic                      bvalid_r;
  logic [1:0]                bresp_r;
  logic                      rvalid_r;
  logic [31:0]               rdata_r;
  logic [1:0]                rresp_r;
  logic                      wr_do;
  logic                      wr_lane;
  logic [`CARSEL_ADDR_W-1:0] wr_addr;
  logic [`CARSEL_ADDR_W-1:0] rd_addr;
  logic [7:0]                rd_byte;
  logic                      rd_hit;
  logic                      wr_hit;

  // ==================================================
  // Datapath state
  logic       pin1_meta_r;
  logic       pin1_r;
  logic       pin2_meta_r;
  logic       pin2_r;
  logic [7:0] car_src;
  logic       car_low_r;
  logic       car_high_r;
  logic       car_low_prev_r;
  logic       car_high_prev_r;
  logic       low_fall;
  logic       high_fall;
  logic       mod_nxt;
  logic       mod_r;
  car_state_t active_r;
  car_state_t active_nxt;
  logic       out_nxt;
  logic       mod_out_r;

  // ==================================================
  // Write channel
  assign s_axil_awready = !aw_ok_r && !bvalid_r;
  assign s_axil_wready  = !w_ok_r && !bvalid_r;
  assign wr_do          = aw_ok_r && w_ok_r;
  assign wr_lane        = wr_do && wstrb_r[0];
  assign wr_addr        = {awaddr_r[`CARSEL_ADDR_W-1:2], 2'h0};

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_ok_r  <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axil_awvalid && s_axil_awready) begin
      aw_ok_r  <= 1'b1;
      awaddr_r <= s_axil_awaddr;
    end else if (wr_do) begin
      aw_ok_r  <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      w_ok_r  <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axil_wvalid && s_axil_wready) begin
      w_ok_r  <= 1'b1;
      wdata_r <= s_axil_wdata;
      wstrb_r <= s_axil_wstrb;
    end else if (wr_do) begin
      w_ok_r  <= 1'b0;
    end
  end

  always_comb begin
    if (wr_addr == `CARSEL_OFS_MAIN) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `CARSEL_OFS_SRC) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `CARSEL_OFS_LOW) begin
      wr_hit = 1'b1;
    end else if (wr_addr == `CARSEL_OFS_HIGH) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `CARSEL_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? `CARSEL_RESP_OKAY : `CARSEL_RESP_ERR;
    end else if (s_axil_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axil_bvalid = bvalid_r;
  assign s_axil_bresp  = bresp_r;

  // ==================================================
  // Register writes
  // Power-on values stand in for the unknown state; no soft reset exists here
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_r <= `CARSEL_CAR_RST;
    end else if (wr_lane && wr_addr == `CARSEL_OFS_LOW) begin
      low_r <= {wdata_r[7:5], wdata_r[3:0]}; // RL8 RL9
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      high_r <= `CARSEL_CAR_RST;
    end else if (wr_lane && wr_addr == `CARSEL_OFS_HIGH) begin
      high_r <= {wdata_r[7:5], wdata_r[3:0]}; // RL10
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      main_r <= `CARSEL_MAIN_RST;
    end else if (wr_lane && wr_addr == `CARSEL_OFS_MAIN) begin
      main_r <= {wdata_r[7:4], wdata_r[0]}; // RL11
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_r <= `CARSEL_SRC_RST;
    end else if (wr_lane && wr_addr == `CARSEL_OFS_SRC) begin
      src_r <= {wdata_r[7], wdata_r[3:0]};
    end
  end

  // ==================================================
  // Read channel
  assign s_axil_arready = !rvalid_r;
  assign rd_addr        = {s_axil_araddr[`CARSEL_ADDR_W-1:2], 2'h0};

  always_comb begin
    rd_hit = 1'b1;
    if (rd_addr == `CARSEL_OFS_MAIN) begin
      rd_byte = {main_r[4:1], mod_out_r, 2'h0, main_r[0]}; // RL11
    end else if (rd_addr == `CARSEL_OFS_SRC) begin
      rd_byte = {src_r[4], 3'h0, src_r[3:0]};
    end else if (rd_addr == `CARSEL_OFS_LOW) begin
      rd_byte = {low_r[6:4], 1'b0, low_r[3:0]}; // RL7 RL9
    end else if (rd_addr == `CARSEL_OFS_HIGH) begin
      rd_byte = {high_r[6:4], 1'b0, high_r[3:0]}; // RL10
    end else begin
      rd_byte = 8'h00;
      rd_hit  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= `CARSEL_RESP_OKAY;
    end else if (s_axil_arvalid && s_axil_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h000000, rd_byte};
      rresp_r  <= rd_hit ? `CARSEL_RESP_OKAY : `CARSEL_RESP_ERR;
    end else if (s_axil_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axil_rvalid = rvalid_r;
  assign s_axil_rdata  = rdata_r;
  assign s_axil_rresp  = rresp_r;

  // ==================================================
  // Pin synchronisers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin1_meta_r <= 1'b0;
      pin1_r      <= 1'b0;
      pin2_meta_r <= 1'b0;
      pin2_r      <= 1'b0;
    end else begin
      pin1_meta_r <= carrier_input_pin_one_i;
      pin1_r      <= pin1_meta_r;
      pin2_meta_r <= carrier_input_pin_two_i;
      pin2_r      <= pin2_meta_r;
    end
  end

  // ==================================================
  // Carrier selection
  // Capture units count only in PWM mode, else they give low
  assign car_src = {capture_compare_out_i & capture_compare_pwm_i, // RL1
                    ref_clock_signal_i,
                    pin2_r, pin1_r, // RL3
                    1'b0}; // RL1

  function automatic logic pick(input carrier_ctrl_t c, input logic [7:0] s);
    logic v;
    v = c.sel[`CARSEL_SEL_RSVD] ? 1'b0 : s[c.sel[2:0]]; // RL2
    return v ^ c.invert; // RL4
  endfunction

  // Registered carriers cost one cycle but give clean edges
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      car_low_r       <= 1'b0;
      car_high_r      <= 1'b0;
      car_low_prev_r  <= 1'b0;
      car_high_prev_r <= 1'b0;
    end else begin
      car_low_r       <= pick(low_r, car_src);
      car_high_r      <= pick(high_r, car_src);
      car_low_prev_r  <= car_low_r;
      car_high_prev_r <= car_high_r;
    end
  end

  assign low_fall  = car_low_prev_r && !car_low_r;
  assign high_fall = car_high_prev_r && !car_high_r;

  // ==================================================
  // Modulation source
  always_comb begin
    if (src_r.modulation_source_select == `CARSEL_SRC_SW) begin
      mod_nxt = main_r.software_modulation_bit;
    end else begin
      mod_nxt = mod_source_i[src_r.modulation_source_select];
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mod_r <= 1'b0;
    end else begin
      mod_r <= mod_nxt;
    end
  end

  // ==================================================
  // Active carrier
  always_comb begin
    active_nxt = active_r;
    case (active_r)
      CAR_LOW: begin
        if (mod_r && (!low_r.edge_sync || low_fall)) begin // RL5 RL6
          active_nxt = CAR_HIGH;
        end
      end
      CAR_HIGH: begin
        if (!mod_r && (!high_r.edge_sync || high_fall)) begin // RL6
          active_nxt = CAR_LOW;
        end
      end
      default: active_nxt = CAR_LOW;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      active_r <= CAR_LOW;
    end else begin
      active_r <= active_nxt;
    end
  end

  // ==================================================
  // Output pin
  assign out_nxt = main_r.modulator_enable &&
                   (((active_nxt == CAR_HIGH) ? car_high_r : car_low_r) // RL12
                    ^ main_r.output_invert);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mod_out_r <= 1'b0;
    end else begin
      mod_out_r <= out_nxt;
    end
  end

  assign mod_out_o               = mod_out_r;
  assign mod_out_oe_o            = main_r.modulator_enable && main_r.modulator_output_enable;
  assign output_slew_limit_o     = main_r.output_slew_limit;
  assign low_carrier_drive_en_o  = !low_r.output_disable; // RL9
  assign high_carrier_drive_en_o = !high_r.output_disable; // RL10
  assign source_drive_en_o       = !src_r.source_output_disable;

  // ==================================================
  // Checks
  ground_sel_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RL1
    low_r.sel == `CARSEL_SEL_GND |=> car_low_r == $past(low_r.invert))
    else $error("ground carrier not low");

  rsvd_sel_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RL2
    high_r.sel[`CARSEL_SEL_RSVD] |=> car_high_r == $past(high_r.invert))
    else $error("reserved code passed a carrier");

  pin_route_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RL3
    low_r.sel == `CARSEL_SEL_PIN2 && !low_r.invert |=> car_low_r == $past(pin2_r))
    else $error("pin two not routed");

  low_invert_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RL4
    low_r.sel == `CARSEL_SEL_PIN1 && low_r.invert |=> car_low_r == !$past(pin1_r))
    else $error("low carrier not inverted");

  sync_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RL5
    active_r == CAR_LOW && mod_r && low_r.edge_sync && !low_fall |=> active_r == CAR_LOW)
    else $error("switched before low carrier fell");

  no_sync_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RL6
    active_r == CAR_HIGH && !mod_r && !high_r.edge_sync |=> active_r == CAR_LOW)
    else $error("unsynced switch delayed");

  bit4_zero_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RL7
    s_axil_arvalid && s_axil_arready && rd_addr == `CARSEL_OFS_LOW
    |=> s_axil_rvalid && s_axil_rdata[4] == 1'b0)
    else $error("low control bit 4 not zero");

  low_write_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RL8
    wr_lane && wr_addr == `CARSEL_OFS_LOW
    |=> low_r.sel == $past(wdata_r[3:0]) && s_axil_bvalid)
    else $error("low control write lost");

  drive_off_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RL9
    wr_lane && wr_addr == `CARSEL_OFS_LOW && wdata_r[7] |=> !low_carrier_drive_en_o)
    else $error("low carrier drive not disabled");

  main_read_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RL11
    s_axil_arvalid && s_axil_arready && rd_addr == `CARSEL_OFS_MAIN
    |=> s_axil_rdata[2:1] == 2'h0 && s_axil_rdata[3] == $past(mod_out_r))
    else $error("main control readback wrong");

  follow_high_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RL12
    main_r.modulator_enable && !main_r.output_invert && mod_r && active_r == CAR_HIGH
    |=> mod_out_o == $past(car_high_r))
    else $error("output not following high carrier");

endmodule

// [tb/carrier_src_model.sv]
// Purpose: far side of the carrier select block: carrier pins and sources
// Assumes: levels come from the bench, one clock shared with the block
// Notes:   the reference signal runs only while run_i is high
module carrier_src_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  // Levels asked by the bench
  input  wire logic [1:0] pin_lvl_i,
  input  wire logic [3:0] ccp_lvl_i,
  input  wire logic [3:0] pwm_i,
  input  wire logic       run_i,
  // Carrier lines
  output logic            pin_one_o,
  output logic            pin_two_o,
  output logic            ref_sig_o,
  output logic [3:0]      ccp_out_o,
  output logic [3:0]      ccp_pwm_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] div_r;

  // ==================================================
  // Static lines
  assign pin_one_o = pin_lvl_i[0];
  assign pin_two_o = pin_lvl_i[1];
  assign ccp_out_o = ccp_lvl_i;
  assign ccp_pwm_o = pwm_i;

  // ==================================================
  // Reference carrier, 16 cycle period
  // Stopped low when idle so no stale edge leaks into a later test
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_r     <= 3'h0;
      ref_sig_o <= 1'b0;
    end else if (run_i) begin
      div_r <= div_r + 3'h1;
      if (div_r == 3'h7) begin
        ref_sig_o <= !ref_sig_o;
      end
    end else begin
      div_r     <= 3'h0;
      ref_sig_o <= 1'b0;
    end
  end
endmodule

// [tb/testbench.sv]
// Purpose: self-checking bench of the modulator carrier select block
// Assumes: software bit is the modulation source (source select 0)
// Notes:   table rows hold carriers still, so latency is not at stake
`include "carsel_map.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] ctl;
    logic [1:0] pins;
    logic [3:0] ccp;
    logic [3:0] pwm;
    logic       exp;
  } row_t;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic        pin1, pin2, ref_sig, mod_out, oe, slew, lde, hde, sde;
  logic [3:0]  ccp_o, pwm_o;
  logic [1:0]  pin_lvl = 2'b00;
  logic [3:0]  ccp_lvl = 4'h0, pwm = 4'h0;
  logic        run = 1'b0;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, ones;
  row_t        rows [14];

  always #4 clk = ~clk;

  // ==================================================
  // Design and far side
  modulator_carrier_select dut_u (
    .ref_clk_i(clk), .sys_rst_i(rst),
    .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_awaddr(awaddr),
    .s_axil_awprot(3'h0), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
    .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_bvalid(bvalid),
    .s_axil_bready(bready), .s_axil_bresp(bresp), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_araddr(araddr), .s_axil_arprot(3'h0),
    .s_axil_rvalid(rvalid), .s_axil_rready(rready), .s_axil_rdata(rdata),
    .s_axil_rresp(rresp), .carrier_input_pin_one_i(pin1),
    .carrier_input_pin_two_i(pin2), .ref_clock_signal_i(ref_sig),
    .capture_compare_out_i(ccp_o), .capture_compare_pwm_i(pwm_o),
    .mod_source_i(16'h0000), .mod_out_o(mod_out), .mod_out_oe_o(oe),
    .output_slew_limit_o(slew), .low_carrier_drive_en_o(lde),
    .high_carrier_drive_en_o(hde), .source_drive_en_o(sde));

  carrier_src_model far_u (
    .ref_clk_i(clk), .sys_rst_i(rst), .pin_lvl_i(pin_lvl), .ccp_lvl_i(ccp_lvl),
    .pwm_i(pwm), .run_i(run), .pin_one_o(pin1), .pin_two_o(pin2),
    .ref_sig_o(ref_sig), .ccp_out_o(ccp_o), .ccp_pwm_o(pwm_o));

  // ==================================================
  // Bus and check tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_p;
    logic w_p;
    @(posedge clk);
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge clk);
      if (aw_p && awready) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ==================================================
  // Main sequence
  initial begin
    rows = '{'{8'h00, 2'b11, 4'hF, 4'hF, 1'b0}, '{8'h40, 2'b00, 4'h0, 4'h0, 1'b1},
             '{8'h01, 2'b01, 4'h0, 4'h0, 1'b1}, '{8'h01, 2'b10, 4'h0, 4'h0, 1'b0},
             '{8'h02, 2'b10, 4'h0, 4'h0, 1'b1}, '{8'h42, 2'b10, 4'h0, 4'h0, 1'b0},
             '{8'h07, 2'b00, 4'h8, 4'h8, 1'b1}, '{8'h07, 2'b00, 4'h8, 4'h0, 1'b0},
             '{8'h06, 2'b00, 4'h4, 4'h4, 1'b1}, '{8'h08, 2'b11, 4'hF, 4'hF, 1'b0},
             '{8'h4F, 2'b11, 4'hF, 4'hF, 1'b1}, '{8'h41, 2'b01, 4'h0, 4'h0, 1'b0},
             '{8'h05, 2'b00, 4'h2, 4'h2, 1'b1}, '{8'h43, 2'b11, 4'hF, 4'hF, 1'b1}};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wr(`CARSEL_OFS_MAIN, 32'hC0, r);
    wr(`CARSEL_OFS_HIGH, 32'h00, r);
    foreach (rows[i]) begin
      @(posedge clk);
      pin_lvl <= rows[i].pins;
      ccp_lvl <= rows[i].ccp;
      pwm <= rows[i].pwm;
      wr(`CARSEL_OFS_LOW, {24'h0, rows[i].ctl}, r);
      repeat (6) @(posedge clk);
      chk(mod_out, rows[i].exp);
    end
    // High carrier while the software bit is set, then output inverted
    wr(`CARSEL_OFS_LOW, 32'h00, r);
    wr(`CARSEL_OFS_HIGH, 32'h02, r);
    wr(`CARSEL_OFS_MAIN, 32'hC1, r);
    repeat (6) @(posedge clk);
    chk(mod_out, 1'b1);
    wr(`CARSEL_OFS_MAIN, 32'hD1, r);
    repeat (6) @(posedge clk);
    chk(mod_out, 1'b0);
    // Switch request while the running low carrier is high
    wr(`CARSEL_OFS_HIGH, 32'h00, r);
    @(posedge clk);
    run <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr(`CARSEL_OFS_LOW, s ? 32'h23 : 32'h03, r);
      wr(`CARSEL_OFS_MAIN, 32'hC0, r);
      while (ref_sig) @(posedge clk);
      while (!ref_sig) @(posedge clk);
      wr(`CARSEL_OFS_MAIN, 32'hC1, r);
      ones = 0;
      repeat (12) begin
        @(posedge clk);
        if (mod_out === 1'b1) ones++;
      end
      chk(ones >= 3, s);
    end
    @(posedge clk);
    run <= 1'b0;
    // Layouts, unused bits and pin gating
    wr(`CARSEL_OFS_LOW, 32'hFF, r);
    rd(`CARSEL_OFS_LOW, d, r);
    chk(d, 32'hEF);
    chk(lde, 1'b0);
    wr(`CARSEL_OFS_HIGH, 32'hFF, r);
    rd(`CARSEL_OFS_HIGH, d, r);
    chk(d, 32'hEF);
    chk(hde, 1'b0);
    wr(`CARSEL_OFS_SRC, 32'hFF, r);
    rd(`CARSEL_OFS_SRC, d, r);
    chk(d, 32'h8F);
    chk(sde, 1'b0);
    wr(`CARSEL_OFS_MAIN, 32'hFF, r);
    rd(`CARSEL_OFS_MAIN, d, r);
    chk(d, 32'hF1);
    chk({oe, slew}, 2'b11);
    // Unmapped place: error answer, nothing read
    wr(8'h10, 32'hFF, r);
    chk(r, `CARSEL_RESP_ERR);
    rd(8'h10, d, r);
    chk(d, 32'h0);
    chk(r, `CARSEL_RESP_ERR);
    // Reset in mid-run clears to the modelled power-on state
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i), d, r);
      chk(d, 32'h0);
    end
    chk({lde, hde, sde, mod_out, oe}, 5'b11100);
    tally_and_finish();
  end
endmodule
